/* crms_defines.vh */
`ifndef CRMS_DEFINES_VH
`define CRMS_DEFINES_VH

// Register byte offsets on APB
`define CRMS_ADDR_CTRL 12'h000
`define CRMS_ADDR_STATUS 12'h004
`define CRMS_ADDR_LEVELS 12'h008

// Control register fields and reset value
`define CRMS_CTRL_FORCE_PWM 0
`define CRMS_CTRL_RESET 32'h00000000

// Status register field positions
`define CRMS_STAT_STATE_LSB 0
`define CRMS_STAT_FAULT 8
`define CRMS_STAT_CORE_PG 9
`define CRMS_STAT_CLOCK_ENABLE_N_N 10
`define CRMS_STAT_DDO 11
`define CRMS_STAT_SKIP 12
`define CRMS_STAT_BLANK 13
`define CRMS_STAT_LOCKOUT_OK 14

// Levels register field positions
`define CRMS_LVL_DAC_LSB 0
`define CRMS_LVL_TARGET_LSB 8

// DAC levels: level L means 12mV + 16mV * L, level 0 means ground
`define CRMS_DAC_ZERO 7'h00
`define CRMS_VID_BASE 7'h6A
`define CRMS_BOOT_BASE 7'h6A
`define CRMS_SUSP_BASE 7'h5A

// Slew-clock counts after the final code
`define CRMS_SETTLE_TICKS 7'h20
`define CRMS_SKIP_EXTRA_TICKS 7'h1E

// Timing in native units and the system clock rate
`define CRMS_CLK_MHZ 125
`define CRMS_CLOCK_ENABLE_N_DELAY_US 50
`define CRMS_PG_HOLD_US 3000

`endif

/* crms_sequencer.v */
`timescale 1ns/1ps
`include "crms_defines.vh"

module crms_sequencer #(
  parameter CLOCK_ENABLE_N_DELAY_CYC = `CRMS_CLOCK_ENABLE_N_DELAY_US * `CRMS_CLK_MHZ,
  parameter PG_HOLD_CYC = `CRMS_PG_HOLD_US * `CRMS_CLK_MHZ,
  parameter TIMER_W = 20
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire por_ok,
  input wire supply_lockout_ok,
  input wire reference_ready,
  input wire feedback_at_target,
  input wire undervoltage_trip,
  input wire overvoltage_trip,
  input wire thermal_trip,
  input wire slew_clock,
  input wire shutdown_n,
  input wire system_power_good_in,
  output wire system_power_good_out,
  output reg system_power_good_oe,
  input wire suspend_request,
  input wire deep_sleep_n,
  input wire [5:0] vid_code,
  input wire [5:0] boot_code_select,
  input wire [5:0] suspend_code_select,
  output reg core_power_good,
  output reg clock_enable_n,
  output wire driver_disable_out,
  output wire low_side_gate,
  output wire high_side_gate,
  output wire switching_enable,
  output wire reference_enable,
  output wire offset_enable,
  output wire pulse_skip_enable,
  output reg [6:0] dac_level
);

  localparam ST_OFF = 5'b00001;
  localparam ST_REF = 5'b00010;
  localparam ST_BOOT = 5'b00100;
  localparam ST_RUN = 5'b01000;
  localparam ST_DOWN = 5'b10000;
  localparam [31:0] CLOCK_ENABLE_N_LAST_FULL = CLOCK_ENABLE_N_DELAY_CYC - 1;
  localparam [31:0] PG_LAST_FULL = PG_HOLD_CYC - 1;
  localparam [TIMER_W-1:0] CLOCK_ENABLE_N_LAST = CLOCK_ENABLE_N_LAST_FULL[TIMER_W-1:0];
  localparam [TIMER_W-1:0] PG_LAST = PG_LAST_FULL[TIMER_W-1:0];

  // Level minus select index, used by all three decoders
  function [6:0] crms_level;
    input [6:0] base;
    input [5:0] idx;
    begin
      crms_level = base - {1'b0, idx};
    end
  endfunction

  // Two-flop synchronisers for every non-APB input pin
  reg [29:0] sync1_reg;
  reg [29:0] sync2_reg;
  wire [29:0] pins;
  assign pins = {por_ok, supply_lockout_ok, reference_ready,
                 feedback_at_target, undervoltage_trip, overvoltage_trip,
                 thermal_trip, slew_clock, shutdown_n, system_power_good_in,
                 suspend_request, deep_sleep_n, vid_code, boot_code_select,
                 suspend_code_select};

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg <= 30'h00000000;
      sync2_reg <= 30'h00000000;
    end else begin
      sync1_reg <= pins;
      sync2_reg <= sync1_reg;
    end
  end

  wire por_s = sync2_reg[29];
  wire lock_s = sync2_reg[28];
  wire ref_s = sync2_reg[27];
  wire fb_s = sync2_reg[26];
  wire uv_s = sync2_reg[25];
  wire ov_s = sync2_reg[24];
  wire therm_s = sync2_reg[23];
  wire slew_s = sync2_reg[22];
  wire shutdown_n_s = sync2_reg[21];
  wire spg_s = sync2_reg[20];
  wire susp_s = sync2_reg[19];
  wire dslp_s = sync2_reg[18];
  wire [5:0] vid_s = sync2_reg[17:12];
  wire [5:0] boot_s = sync2_reg[11:6];
  wire [5:0] ssel_s = sync2_reg[5:0];

  reg [4:0] state_reg;
  reg [4:0] state_next;
  reg fault_reg;
  reg slew_prev_reg;
  reg shutdown_n_prev_reg;
  reg spg_prev_reg;
  reg [6:0] boot_lvl_reg;
  reg [6:0] susp_lvl_reg;
  reg [6:0] settle_reg;
  reg [TIMER_W-1:0] timer_reg;
  reg pg_done_reg;
  reg [31:0] ctrl_reg;
  reg [6:0] target;

  // Edge detection on synchronised levels
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slew_prev_reg <= 1'b0;
      shutdown_n_prev_reg <= 1'b0;
      spg_prev_reg <= 1'b0;
    end else begin
      slew_prev_reg <= slew_s;
      shutdown_n_prev_reg <= shutdown_n_s;
      spg_prev_reg <= spg_s;
    end
  end

  wire tick = slew_s & ~slew_prev_reg;
  wire shutdown_n_rise = shutdown_n_s & ~shutdown_n_prev_reg;
  wire active = |(state_reg & (ST_BOOT | ST_RUN));
  wire spg_fall = spg_prev_reg & ~spg_s & active & shutdown_n_s;
  wire at_target = (dac_level == target);
  wire blank = (settle_reg < `CRMS_SETTLE_TICKS);
  wire uv_hit = uv_s & active & at_target & ~blank;
  wire fault_set = spg_fall | uv_hit | (ov_s & active) |
                   (therm_s & lock_s);
  wire fault_clr = shutdown_n_rise | ~por_s;
  wire shut = ~shutdown_n_s | fault_set | fault_reg;
  wire vid_mode = (state_reg == ST_RUN) & ~susp_s;

  // Fault latch, a new fault beats a clear
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_reg <= 1'b0;
    end else if (fault_set) begin
      fault_reg <= 1'b1;
    end else if (fault_clr) begin
      fault_reg <= 1'b0;
    end
  end

  // Target level mux by mode
  always @* begin
    case (state_reg)
      ST_BOOT: target = boot_lvl_reg;
      ST_RUN: begin
        if (susp_s) begin
          target = susp_lvl_reg;
        end else begin
          target = crms_level(`CRMS_VID_BASE, vid_s);
        end
      end
      default: target = `CRMS_DAC_ZERO;
    endcase
  end

  // Sequencer state transitions
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_OFF: begin
        if (lock_s & shutdown_n_s & ~fault_reg & ~fault_set) begin
          state_next = ST_REF;
        end
      end
      ST_REF: begin
        if (shut) begin
          state_next = ST_OFF;
        end else if (ref_s) begin
          state_next = ST_BOOT;
        end
      end
      ST_BOOT: begin
        if (shut) begin
          state_next = ST_DOWN;
        end else if (timer_reg == CLOCK_ENABLE_N_LAST) begin
          state_next = ST_RUN;
        end
      end
      ST_RUN: begin
        if (shut) begin
          state_next = ST_DOWN;
        end
      end
      ST_DOWN: begin
        if (dac_level == `CRMS_DAC_ZERO) begin
          state_next = ST_OFF;
        end
      end
      default: state_next = ST_OFF;
    endcase
    if (!lock_s) begin
      state_next = ST_OFF;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_OFF;
    end else begin
      state_reg <= state_next;
    end
  end

  // Boot and suspend codes caught on the way to boot
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boot_lvl_reg <= `CRMS_DAC_ZERO;
      susp_lvl_reg <= `CRMS_DAC_ZERO;
    end else if (state_reg == ST_REF && state_next == ST_BOOT) begin
      boot_lvl_reg <= crms_level(`CRMS_BOOT_BASE, boot_s);
      susp_lvl_reg <= crms_level(`CRMS_SUSP_BASE, ssel_s);
    end
  end

  // DAC stepper, one 16mV code per slew tick
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dac_level <= `CRMS_DAC_ZERO;
    end else if (!lock_s || state_reg == ST_OFF) begin
      dac_level <= `CRMS_DAC_ZERO;
    end else if (tick && !at_target) begin
      if (dac_level < target) begin
        dac_level <= dac_level + 7'h01;
      end else begin
        dac_level <= dac_level - 7'h01;
      end
    end
  end

  // Slew ticks counted since the final code was reached
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      settle_reg <= 7'h00;
    end else if (!at_target) begin
      settle_reg <= 7'h00;
    end else if (tick && settle_reg <
                 (`CRMS_SETTLE_TICKS + `CRMS_SKIP_EXTRA_TICKS)) begin
      settle_reg <= settle_reg + 7'h01;
    end
  end

  // Shared timer: clock enable delay in boot, power-good hold in run
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_reg <= {TIMER_W{1'b0}};
      pg_done_reg <= 1'b0;
    end else if (state_reg == ST_BOOT) begin
      pg_done_reg <= 1'b0;
      if (state_next == ST_RUN || !(spg_s && fb_s && at_target)) begin
        timer_reg <= {TIMER_W{1'b0}};
      end else begin
        timer_reg <= timer_reg + 1'b1;
      end
    end else if (state_reg == ST_RUN) begin
      if (timer_reg == PG_LAST) begin
        pg_done_reg <= 1'b1;
      end else begin
        timer_reg <= timer_reg + 1'b1;
      end
    end else begin
      timer_reg <= {TIMER_W{1'b0}};
      pg_done_reg <= 1'b0;
    end
  end

  // Clock enable and core power-good outputs
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clock_enable_n <= 1'b1;
      core_power_good <= 1'b0;
    end else if (shut || state_reg != ST_RUN) begin
      core_power_good <= 1'b0;
      if (state_reg == ST_BOOT && state_next == ST_RUN) begin
        clock_enable_n <= 1'b0;
      end else begin
        clock_enable_n <= 1'b1;
      end
    end else if (pg_done_reg && !blank && !fault_reg) begin
      core_power_good <= 1'b1;
    end
  end

  // Open-drain power-good pin held low until reference is ready
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      system_power_good_oe <= 1'b1;
    end else begin
      system_power_good_oe <= ~(ref_s & reference_enable);
    end
  end
  assign system_power_good_out = 1'b0;

  // Mode outputs decoded from registered state
  wire forced = ~lock_s | (state_reg == ST_OFF) | (state_reg == ST_REF);
  wire susp_mode = (state_reg == ST_RUN) & susp_s;
  wire dslp_mode = vid_mode & ~dslp_s;
  assign low_side_gate = forced;
  assign high_side_gate = 1'b0;
  assign switching_enable = ~forced;
  assign reference_enable = (state_reg != ST_OFF);
  assign offset_enable = dslp_mode;
  assign driver_disable_out = (state_reg == ST_BOOT) |
                              (vid_mode & dslp_s) |
                              (susp_mode & blank);
  assign pulse_skip_enable = ~ctrl_reg[`CRMS_CTRL_FORCE_PWM] &
                             (dslp_mode | (susp_mode & (settle_reg ==
                             (`CRMS_SETTLE_TICKS +
                              `CRMS_SKIP_EXTRA_TICKS))));

  // APB slave, zero wait states
  wire setup = psel & ~penable;
  wire access = psel & penable;
  wire mapped = (paddr == `CRMS_ADDR_CTRL) | (paddr == `CRMS_ADDR_STATUS) |
                (paddr == `CRMS_ADDR_LEVELS);
  assign pready = 1'b1;
  assign pslverr = access & ~mapped;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= `CRMS_CTRL_RESET;
    end else if (access && pwrite && paddr == `CRMS_ADDR_CTRL) begin
      ctrl_reg <= {31'h00000000, pwdata[`CRMS_CTRL_FORCE_PWM]};
    end
  end

  // Read data captured in the setup cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (setup && !pwrite) begin
      prdata <= 32'h00000000;
      case (paddr)
        `CRMS_ADDR_CTRL: prdata <= ctrl_reg;
        `CRMS_ADDR_STATUS: begin
          prdata[`CRMS_STAT_STATE_LSB +: 5] <= state_reg;
          prdata[`CRMS_STAT_FAULT] <= fault_reg;
          prdata[`CRMS_STAT_CORE_PG] <= core_power_good;
          prdata[`CRMS_STAT_CLOCK_ENABLE_N_N] <= clock_enable_n;
          prdata[`CRMS_STAT_DDO] <= driver_disable_out;
          prdata[`CRMS_STAT_SKIP] <= pulse_skip_enable;
          prdata[`CRMS_STAT_BLANK] <= blank;
          prdata[`CRMS_STAT_LOCKOUT_OK] <= lock_s;
        end
        `CRMS_ADDR_LEVELS: begin
          prdata[`CRMS_LVL_DAC_LSB +: 7] <= dac_level;
          prdata[`CRMS_LVL_TARGET_LSB +: 7] <= target;
        end
        default: prdata <= 32'h00000000;
      endcase
    end
  end

endmodule

/* crms_host_model.sv */
`timescale 1ns/1ps
module crms_host_model #(
  parameter [5:0] BOOT_SEL = 6'h00,
  parameter [5:0] SUSP_SEL = 6'h00
) (
  input wire pclk,
  input wire [5:0] vid_req,
  input wire pg_req,
  input wire system_power_good_oe,
  output reg [5:0] vid_code = 6'h00,
  output wire system_power_good_in,
  output wire [5:0] boot_code_select,
  output wire [5:0] suspend_code_select
);
  // All six code bits leave on one edge
  always @(posedge pclk) begin
    vid_code <= vid_req;
  end
  // Strapped selects never move
  assign boot_code_select = BOOT_SEL;
  assign suspend_code_select = SUSP_SEL;
  // Open-drain power-good line with pull-up
  assign system_power_good_in = pg_req && !system_power_good_oe;
endmodule

/* crms_seq_asserts.sv */
`timescale 1ns/1ps
module crms_seq_asserts #(
  parameter CLOCK_ENABLE_N_DELAY_CYC = 20,
  parameter PG_HOLD_CYC = 50,
  parameter TIMER_W = 20
) (
  input wire pclk,
  input wire presetn,
  input wire shutdown_n,
  input wire system_power_good_in,
  input wire system_power_good_oe,
  input wire supply_lockout_ok,
  input wire reference_ready,
  input wire core_power_good,
  input wire clock_enable_n,
  input wire driver_disable_out,
  input wire low_side_gate,
  input wire high_side_gate,
  input wire switching_enable,
  input wire reference_enable,
  input wire [6:0] dac_level
);
  reg [TIMER_W-1:0] good_cnt_reg;
  reg [TIMER_W-1:0] low_cnt_reg;
  // Run lengths of power-good high and clock enable low
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      good_cnt_reg <= '0;
      low_cnt_reg <= '0;
    end else begin
      good_cnt_reg <= system_power_good_in ? good_cnt_reg + 1'b1 : '0;
      low_cnt_reg <= clock_enable_n ? '0 : low_cnt_reg + 1'b1;
    end
  end
  default clocking chk_cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Behaviour at the pins
  shut_pg_low_a:
    assert property ((!shutdown_n || !system_power_good_in) [*4] |->
      !core_power_good && clock_enable_n) else $error("pg or clock_enable_n wrong");
  lockout_gate_a:
    assert property (!supply_lockout_ok [*4] |-> low_side_gate &&
      !high_side_gate && !switching_enable) else $error("gates not forced");
  dac_step_a:
    assert property (supply_lockout_ok [*5] ##0 $changed(dac_level) |->
      dac_level == $past(dac_level) + 7'h01 ||
      dac_level + 7'h01 == $past(dac_level)) else $error("dac jumped");
  ref_off_zero_a:
    assert property ((!shutdown_n && dac_level == 7'h00) [*8] |->
      !reference_enable && low_side_gate && !switching_enable)
    else $error("reference not off at zero");
  shut_ddo_a:
    assert property (!shutdown_n [*5] |-> !driver_disable_out)
    else $error("ddo high in shutdown");
  sysok_release_a:
    assert property (!reference_ready [*5] |-> system_power_good_oe)
    else $error("power-good released early");
  clock_enable_n_delay_a:
    assert property ($fell(clock_enable_n) |->
      good_cnt_reg >= CLOCK_ENABLE_N_DELAY_CYC) else $error("clock_enable_n fell early");
  pg_hold_a:
    assert property ($rose(core_power_good) |-> !clock_enable_n &&
      low_cnt_reg >= PG_HOLD_CYC) else $error("core pg rose early");
  // Main scenarios reached
  cover property ($fell(clock_enable_n));
  cover property ($rose(core_power_good));
  cover property ($fell(driver_disable_out));
endmodule
bind crms_sequencer crms_seq_asserts #(
  .CLOCK_ENABLE_N_DELAY_CYC(CLOCK_ENABLE_N_DELAY_CYC),
  .PG_HOLD_CYC(PG_HOLD_CYC),
  .TIMER_W(TIMER_W)
) i_crms_seq_asserts (
  .pclk(pclk),
  .presetn(presetn),
  .shutdown_n(shutdown_n),
  .system_power_good_in(system_power_good_in),
  .system_power_good_oe(system_power_good_oe),
  .supply_lockout_ok(supply_lockout_ok),
  .reference_ready(reference_ready),
  .core_power_good(core_power_good),
  .clock_enable_n(clock_enable_n),
  .driver_disable_out(driver_disable_out),
  .low_side_gate(low_side_gate),
  .high_side_gate(high_side_gate),
  .switching_enable(switching_enable),
  .reference_enable(reference_enable),
  .dac_level(dac_level)
);

/* crms_sequencer_bench.sv */
`timescale 1ns/1ps
module crms_sequencer_bench;
  localparam [5:0] BOOT_SEL = 6'h3F;
  localparam [5:0] SUSP_SEL = 6'h1B;
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0;
  logic pwrite = 1'h0, por_ok = 1'h0, supply_lockout_ok = 1'h0;
  logic reference_ready = 1'h0, thermal_trip = 1'h0, slew_clock = 1'h0;
  logic shutdown_n = 1'h0, pg_req = 1'h0, suspend_request = 1'h0;
  logic deep_sleep_n = 1'h1, e;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, q;
  logic [5:0] vid_req = 6'h00;
  logic feedback_at_target = 1'h1;
  logic undervoltage_trip = 1'h0;
  logic overvoltage_trip = 1'h0;
  wire [31:0] prdata;
  wire [6:0] dac_level;
  wire [5:0] vid_code, boot_code_select, suspend_code_select;
  wire pready, pslverr, system_power_good_in, system_power_good_out;
  wire system_power_good_oe, core_power_good, clock_enable_n;
  wire driver_disable_out, low_side_gate, high_side_gate, offset_enable;
  wire switching_enable, reference_enable, pulse_skip_enable;
  int err_count = 0, tests_run = 0, n;
  int vq[$] = '{63, 0, 21};
  // Bus clock, slew oscillator, reference settling
  always #4 pclk = ~pclk;
  always #33 slew_clock = ~slew_clock;
  always @(posedge pclk) reference_ready <= reference_enable;
  crms_sequencer #(.CLOCK_ENABLE_N_DELAY_CYC(20), .PG_HOLD_CYC(50))
    i_crms_sequencer (.*);
  crms_host_model #(.BOOT_SEL(BOOT_SEL), .SUSP_SEL(SUSP_SEL))
    i_crms_host_model (.*);
  // Code select to index, top level first
  function int idx(input logic [5:0] s);
    return s[5:4] * 16 + s[3:2] * 4 + s[1:0];
  endfunction
  task cmp(input string nm, input logic [31:0] ex, got);
    tests_run++;
    if (got !== ex) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, ex, got);
    end
  endtask
  // One APB transfer, result in q and e
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1) @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask
  task ramp(input int t);
    for (n = 0; n < 5000 && dac_level !== t[6:0]; n++) @(posedge pclk);
    cmp("dac_level", t, dac_level);
  endtask
  task results;
    if (err_count == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Hang guard
  initial begin
    #400000;
    err_count++;
    results;
  end
  // Main sequence
  initial begin
    void'($urandom(32'h3BABE105));
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    apb(1'h0, 12'h004, 32'h0);
    cmp("status", 32'h401, q & 32'hF1F);
    cmp("low_side_gate", 1, low_side_gate);
    cmp("high_side_gate", 0, high_side_gate);
    apb(1'h0, 12'h00C, 32'h0);
    cmp("pslverr", 1, e);
    cmp("prdata", 0, q);
    n = $urandom;
    apb(1'h1, 12'h000, n);
    apb(1'h0, 12'h000, 32'h0);
    cmp("ctrl", n & 1, q);
    apb(1'h1, 12'h000, 32'h0);
    // Power-up to boot, then hand-off
    por_ok <= 1'h1;
    supply_lockout_ok <= 1'h1;
    shutdown_n <= 1'h1;
    ramp(106 - idx(BOOT_SEL));
    cmp("ddo", 1, driver_disable_out);
    cmp("clock_enable_n_n", 1, clock_enable_n);
    cmp("pg_oe", 0, system_power_good_oe);
    cmp("pg_out", 0, system_power_good_out);
    feedback_at_target <= 1'h0;
    pg_req <= 1'h1;
    repeat (40) @(posedge pclk);
    cmp("clock_enable_n_n", 1, clock_enable_n);
    feedback_at_target <= 1'h1;
    for (n = 0; n < 500 && clock_enable_n !== 1'h0; n++) @(posedge pclk);
    cmp("clock_enable_n_n", 0, clock_enable_n);
    cmp("clock_enable_n_delay", 1, n >= 20 && n < 30);
    ramp(106);
    apb(1'h0, 12'h008, 32'h0);
    cmp("levels", 32'h6A6A, q);
    for (n = 0; n < 3000 && core_power_good !== 1'h1; n++) @(posedge pclk);
    cmp("core_pg", 1, core_power_good);
    cmp("offset", 0, offset_enable);
    cmp("ddo", 1, driver_disable_out);
    vq.push_back($urandom_range(62, 44));
    foreach (vq[i]) begin
      vid_req <= vq[i][5:0];
      ramp(106 - vq[i]);
      cmp("core_pg", 1, core_power_good);
    end
    // Deep sleep, then suspend
    deep_sleep_n <= 1'h0;
    repeat (4) @(posedge pclk);
    cmp("ddo", 0, driver_disable_out);
    cmp("offset", 1, offset_enable);
    cmp("skip", 1, pulse_skip_enable);
    apb(1'h1, 12'h000, 32'h1);
    cmp("skip", 0, pulse_skip_enable);
    apb(1'h1, 12'h000, 32'h0);
    deep_sleep_n <= 1'h1;
    suspend_request <= 1'h1;
    ramp(90 - idx(SUSP_SEL));
    for (n = 0; n < 600 && driver_disable_out !== 1'h0; n++) @(posedge pclk);
    cmp("ddo_delay", 1, n > 250 && n < 290);
    for (n = 0; n < 600 && pulse_skip_enable !== 1'h1; n++) @(posedge pclk);
    cmp("skip_delay", 1, n > 230 && n < 260);
    apb(1'h0, 12'h004, 32'h0);
    cmp("status", 32'h5208, q);
    suspend_request <= 1'h0;
    ramp(106 - vq[3]);
    // Power-good loss latches a fault
    pg_req <= 1'h0;
    repeat (4) @(posedge pclk);
    cmp("core_pg", 0, core_power_good);
    cmp("clock_enable_n_n", 1, clock_enable_n);
    ramp(0);
    repeat (8) @(posedge pclk);
    cmp("ref_en", 0, reference_enable);
    cmp("lsg", 1, low_side_gate);
    apb(1'h0, 12'h004, 32'h0);
    cmp("fault", 1, q[8]);
    pg_req <= 1'h1;
    repeat (20) @(posedge pclk);
    cmp("ref_en", 0, reference_enable);
    shutdown_n <= 1'h0;
    repeat (4) @(posedge pclk);
    cmp("ddo", 0, driver_disable_out);
    shutdown_n <= 1'h1;
    ramp(106 - idx(BOOT_SEL));
    // Thermal fault, cleared by supply reset
    thermal_trip <= 1'h1;
    ramp(0);
    thermal_trip <= 1'h0;
    por_ok <= 1'h0;
    repeat (4) @(posedge pclk);
    apb(1'h0, 12'h004, 32'h0);
    cmp("fault", 0, q[8]);
    por_ok <= 1'h1;
    ramp(106 - idx(BOOT_SEL));
    supply_lockout_ok <= 1'h0;
    repeat (4) @(posedge pclk);
    cmp("dac_level", 0, dac_level);
    cmp("lsg", 1, low_side_gate);
    cmp("sw_en", 0, switching_enable);
    // Overvoltage and undervoltage faults
    supply_lockout_ok <= 1'h1;
    ramp(106 - idx(BOOT_SEL));
    overvoltage_trip <= 1'h1;
    ramp(0);
    overvoltage_trip <= 1'h0;
    apb(1'h0, 12'h004, 32'h0);
    cmp("fault", 1, q[8]);
    shutdown_n <= 1'h0;
    repeat (4) @(posedge pclk);
    shutdown_n <= 1'h1;
    undervoltage_trip <= 1'h1;
    ramp(106 - idx(BOOT_SEL));
    ramp(106 - vq[3]);
    ramp(0);
    undervoltage_trip <= 1'h0;
    results;
  end
endmodule
